// File: verilog/csaf_top.sv
// csaf_top: two channel setup registers, hysteresis gating and data average
// assumes a register port from the serial decoder and conversion pulses on clk_in
//
// Overview of operation
// RULE_01 - two 8-bit setup registers, preset 0x0b
// RULE_02 - range bits pick input range, dac step
// RULE_03 - hysteresis bit disables hysteresis in adaptive
// RULE_04 - fixed threshold mode never uses hysteresis
// RULE_05 - time constant is two to exponent plus one
// RULE_06 - time constant spans 2 to 65536 cycles
// RULE_07 - average approaches new data exponentially
// RULE_08 - adaptive thresholds come from the average
// RULE_09 - config bit zero selects adaptive mode
// RULE_10 - timeout reloads average with latest data
// RULE_11 - controller writes zero to bit five
`timescale 1ns/1ps
module csaf_top
    import csaf_pkg::*;
#(
    parameter int DATA_W = CSAF_DATA_W
)(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_ptr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // mode and sensitivity
    input wire logic fixed_threshold_select_in,
    input wire logic [7:0] sens1_in,
    input wire logic [7:0] sens2_in,
    // conversions
    input wire logic conv_done1_in,
    input wire logic conv_done2_in,
    input wire logic [DATA_W-1:0] conv_data_in,
    input wire logic timeout1_in,
    input wire logic timeout2_in,
    // per channel results
    output logic [4:0] range_qpf1_out,
    output logic [4:0] range_qpf2_out,
    output logic [3:0] offset_dac_step1_out,
    output logic [3:0] offset_dac_step2_out,
    output logic hyst_en1_out,
    output logic hyst_en2_out,
    output logic [16:0] average_time_constant1_out,
    output logic [16:0] average_time_constant2_out,
    output logic [DATA_W-1:0] thr_pos1_out,
    output logic [DATA_W-1:0] thr_neg1_out,
    output logic [DATA_W-1:0] thr_pos2_out,
    output logic [DATA_W-1:0] thr_neg2_out
);
    logic [7:0] setup1_r, setup1_nxt, setup2_r, setup2_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [4:0] q1_r, q1_nxt, q2_r, q2_nxt;
    logic [3:0] st1_r, st1_nxt, st2_r, st2_nxt;
    logic h1_r, h1_nxt, h2_r, h2_nxt;
    logic [16:0] tc1_r, tc1_nxt, tc2_r, tc2_nxt;
    logic [DATA_W-1:0] p1_r, p1_nxt, n1_r, n1_nxt, p2_r, p2_nxt, n2_r, n2_nxt;
    logic [DATA_W-1:0] avg1, avg2;

    // range decode to input range and dac step
    function automatic logic [4:0] rng_qpf(input logic [1:0] r);
        case (r)
            CSAF_RNG_2PF: rng_qpf = CSAF_QPF_2PF;
            CSAF_RNG_HALF: rng_qpf = CSAF_QPF_HALF;
            CSAF_RNG_1PF: rng_qpf = CSAF_QPF_1PF;
            default: rng_qpf = CSAF_QPF_4PF;
        endcase
    endfunction
    function automatic logic [3:0] rng_step(input logic [1:0] r);
        case (r)
            CSAF_RNG_2PF: rng_step = CSAF_STEP_2PF;
            CSAF_RNG_HALF: rng_step = CSAF_STEP_HALF;
            CSAF_RNG_1PF: rng_step = CSAF_STEP_1PF;
            default: rng_step = CSAF_STEP_4PF;
        endcase
    endfunction
    // threshold = average +/- sensitivity, saturated
    function automatic logic [DATA_W-1:0] thr_add(input logic [DATA_W-1:0] a, input logic [7:0] s);
        logic [DATA_W:0] t;
        t = {1'b0, a} + (DATA_W+1)'(s);
        thr_add = t[DATA_W] ? '1 : t[DATA_W-1:0];
    endfunction
    function automatic logic [DATA_W-1:0] thr_sub(input logic [DATA_W-1:0] a, input logic [7:0] s);
        thr_sub = (a < DATA_W'(s)) ? '0 : a - DATA_W'(s);
    endfunction

    // register writes and reads
    always_comb
    begin
        setup1_nxt = setup1_r;
        setup2_nxt = setup2_r;
        if (reg_wr_in && reg_ptr_in == CSAF_SETUP1_PTR)
            setup1_nxt = reg_wdata_in; // RULE_01
        if (reg_wr_in && reg_ptr_in == CSAF_SETUP2_PTR)
            setup2_nxt = reg_wdata_in; // RULE_01
        case (reg_ptr_in)
            CSAF_SETUP1_PTR: rdata_nxt = setup1_r;
            CSAF_SETUP2_PTR: rdata_nxt = setup2_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            setup1_r <= CSAF_SETUP_RST; // RULE_01
            setup2_r <= CSAF_SETUP_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            setup1_r <= setup1_nxt;
            setup2_r <= setup2_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // field decode per channel
    always_comb
    begin
        q1_nxt = rng_qpf(setup1_r[CSAF_RANGE_HI_BIT:CSAF_RANGE_LO_BIT]); // RULE_02
        q2_nxt = rng_qpf(setup2_r[CSAF_RANGE_HI_BIT:CSAF_RANGE_LO_BIT]);
        st1_nxt = rng_step(setup1_r[CSAF_RANGE_HI_BIT:CSAF_RANGE_LO_BIT]); // RULE_02
        st2_nxt = rng_step(setup2_r[CSAF_RANGE_HI_BIT:CSAF_RANGE_LO_BIT]);
        // adaptive only when fixed select is zero
        h1_nxt = !fixed_threshold_select_in && !setup1_r[CSAF_HYST_DIS_BIT]; // RULE_03 RULE_04 RULE_09
        h2_nxt = !fixed_threshold_select_in && !setup2_r[CSAF_HYST_DIS_BIT]; // RULE_03 RULE_04 RULE_09
        tc1_nxt = 17'h00002 << setup1_r[CSAF_SETTLE_MSB:0]; // RULE_05 RULE_06
        tc2_nxt = 17'h00002 << setup2_r[CSAF_SETTLE_MSB:0]; // RULE_05 RULE_06
        p1_nxt = thr_add(avg1, sens1_in); // RULE_08
        n1_nxt = thr_sub(avg1, sens1_in); // RULE_08
        p2_nxt = thr_add(avg2, sens2_in);
        n2_nxt = thr_sub(avg2, sens2_in);
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            q1_r <= CSAF_QPF_2PF;
            q2_r <= CSAF_QPF_2PF;
            st1_r <= CSAF_STEP_2PF;
            st2_r <= CSAF_STEP_2PF;
            h1_r <= 1'b0;
            h2_r <= 1'b0;
            tc1_r <= 17'h00002;
            tc2_r <= 17'h00002;
            p1_r <= '0;
            n1_r <= '0;
            p2_r <= '0;
            n2_r <= '0;
        end
        else
        begin
            q1_r <= q1_nxt;
            q2_r <= q2_nxt;
            st1_r <= st1_nxt;
            st2_r <= st2_nxt;
            h1_r <= h1_nxt;
            h2_r <= h2_nxt;
            tc1_r <= tc1_nxt;
            tc2_r <= tc2_nxt;
            p1_r <= p1_nxt;
            n1_r <= n1_nxt;
            p2_r <= p2_nxt;
            n2_r <= n2_nxt;
        end
    end

    // one average filter per channel
    csaf_avg_chan #(.DATA_W(DATA_W)) u_avg1 (
        .clk_in(clk_in), .rstn_in(rstn_in), .conv_done_in(conv_done1_in),
        .conv_data_in(conv_data_in), .timeout_in(timeout1_in),
        .settle_exp_in(setup1_r[CSAF_SETTLE_MSB:0]), .avg_out(avg1));
    csaf_avg_chan #(.DATA_W(DATA_W)) u_avg2 (
        .clk_in(clk_in), .rstn_in(rstn_in), .conv_done_in(conv_done2_in),
        .conv_data_in(conv_data_in), .timeout_in(timeout2_in),
        .settle_exp_in(setup2_r[CSAF_SETTLE_MSB:0]), .avg_out(avg2));

    assign reg_rdata_out = rdata_r;
    assign range_qpf1_out = q1_r;
    assign range_qpf2_out = q2_r;
    assign offset_dac_step1_out = st1_r;
    assign offset_dac_step2_out = st2_r;
    assign hyst_en1_out = h1_r;
    assign hyst_en2_out = h2_r;
    assign average_time_constant1_out = tc1_r;
    assign average_time_constant2_out = tc2_r;
    assign thr_pos1_out = p1_r;
    assign thr_neg1_out = n1_r;
    assign thr_pos2_out = p2_r;
    assign thr_neg2_out = n2_r;

    chk_setup_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_01
        reg_wr_in && reg_ptr_in == CSAF_SETUP1_PTR |=> setup1_r == $past(reg_wdata_in))
        else $error("setup one write lost");
    chk_range_step: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_02
        setup1_r[7:6] == 2'h1 |=> offset_dac_step1_out == 4'h1 && range_qpf1_out == 5'h02)
        else $error("range decode wrong");
    chk_hyst_fixed: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_04
        fixed_threshold_select_in |=> !hyst_en1_out && !hyst_en2_out)
        else $error("hysteresis in fixed mode");
    chk_hyst_adapt: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
        !fixed_threshold_select_in && !setup2_r[4] |=> hyst_en2_out)
        else $error("hysteresis missing in adaptive mode");
    chk_tc_span: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_06
        setup1_r[3:0] == 4'hf |=> average_time_constant1_out == 17'h10000)
        else $error("time constant span wrong");
    chk_tc_double: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_05
        setup2_r[3:0] == 4'h0 |=> average_time_constant2_out == 17'h00002)
        else $error("time constant base wrong");
    chk_thr_avg: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_08
        thr_pos1_out >= $past(avg1) && thr_neg1_out <= $past(avg1))
        else $error("thresholds not around the average");
    chk_adapt_sel: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_09
        !fixed_threshold_select_in && setup1_r[4] |=> !hyst_en1_out)
        else $error("hysteresis disable ignored");
endmodule // csaf_top

// File: verilog/csaf_pkg.sv
// csaf_pkg: constants for the per-channel setup and average filter block
// assumes an 8-bit register port driven by a serial interface decoder
package csaf_pkg;
    localparam logic [7:0] CSAF_SETUP1_PTR = 8'h0b;
    localparam logic [7:0] CSAF_SETUP2_PTR = 8'h0e;
    localparam logic [7:0] CSAF_SETUP_RST = 8'h0b;
    localparam int CSAF_RANGE_HI_BIT = 7;
    localparam int CSAF_RANGE_LO_BIT = 6;
    localparam int CSAF_RSVD_BIT = 5;
    localparam int CSAF_HYST_DIS_BIT = 4;
    localparam int CSAF_SETTLE_MSB = 3;
    localparam int CSAF_DATA_W = 12;
    localparam int CSAF_FRAC_W = 17;
    // input range codes in quarter pF and dac steps
    localparam logic [1:0] CSAF_RNG_2PF = 2'h0;
    localparam logic [1:0] CSAF_RNG_HALF = 2'h1;
    localparam logic [1:0] CSAF_RNG_1PF = 2'h2;
    localparam logic [1:0] CSAF_RNG_4PF = 2'h3;
    localparam logic [4:0] CSAF_QPF_2PF = 5'h08;
    localparam logic [4:0] CSAF_QPF_HALF = 5'h02;
    localparam logic [4:0] CSAF_QPF_1PF = 5'h04;
    localparam logic [4:0] CSAF_QPF_4PF = 5'h10;
    localparam logic [3:0] CSAF_STEP_2PF = 4'h4;
    localparam logic [3:0] CSAF_STEP_HALF = 4'h1;
    localparam logic [3:0] CSAF_STEP_1PF = 4'h2;
    localparam logic [3:0] CSAF_STEP_4PF = 4'h8;
    typedef enum logic [1:0] {CSAF_IDLE, CSAF_UPDATE} csaf_state_t;
endpackage

// File: verilog/csaf_avg_chan.sv
// csaf_avg_chan: exponential data average of one channel
// assumes conv_done_in is a one-cycle pulse from same-clock logic
`timescale 1ns/1ps
module csaf_avg_chan
    import csaf_pkg::*;
#(
    parameter int DATA_W = CSAF_DATA_W,
    parameter int FRAC_W = CSAF_FRAC_W
)(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // conversion input
    input wire logic conv_done_in,
    input wire logic [DATA_W-1:0] conv_data_in,
    input wire logic timeout_in,
    input wire logic [3:0] settle_exp_in,
    // average output
    output logic [DATA_W-1:0] avg_out
);
    logic [DATA_W+FRAC_W-1:0] acc_r, acc_nxt;
    logic signed [DATA_W+FRAC_W:0] diff;
    logic [4:0] shift;

    // avg += (data - avg) / 2^(exp+1), or reload on timeout
    always_comb
    begin
        shift = 5'(settle_exp_in) + 5'h01; // RULE_05
        diff = $signed({1'b0, conv_data_in, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_r});
        acc_nxt = acc_r;
        if (conv_done_in)
        begin
            if (timeout_in)
                acc_nxt = {conv_data_in, {FRAC_W{1'b0}}}; // RULE_10
            else
                acc_nxt = (DATA_W+FRAC_W)'($signed({1'b0, acc_r}) + (diff >>> shift)); // RULE_07
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            acc_r <= '0;
        else
            acc_r <= acc_nxt;
    end

    assign avg_out = acc_r[DATA_W+FRAC_W-1:FRAC_W];

    chk_avg_reload: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_10
        conv_done_in && timeout_in |=> avg_out == $past(conv_data_in))
        else $error("average not reloaded on timeout");
    chk_avg_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_07
        !conv_done_in |=> $stable(acc_r))
        else $error("average moved without conversion");
endmodule // csaf_avg_chan

// File: tb/csaf_host_model.sv
// csaf_host_model: controller writing setup registers
// assumes its tasks are called after reset, on clk_in
`timescale 1ns/1ps
module csaf_host_model (
    // clock
    input wire logic clk_in,
    // register port
    output logic reg_wr_out,
    output logic [7:0] reg_ptr_out,
    output logic [7:0] reg_wdata_out
);
    // idle bus
    initial
    begin
        reg_wr_out = 1'b0;
        reg_ptr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end
    // one write byte, bit five always cleared
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(negedge clk_in);
        reg_wr_out = 1'b1;
        reg_ptr_out = p;
        reg_wdata_out = d & 8'hdf;
        @(negedge clk_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~reg_wdata_out; // released data
        @(negedge clk_in);
    endtask
    // select a pointer for reading
    task automatic point(input logic [7:0] p);
        @(negedge clk_in);
        reg_ptr_out = p;
        @(negedge clk_in);
    endtask
endmodule // csaf_host_model

// File: tb/tb_top.sv
// tb_top: self-checking bench of the setup and average block
// assumes csaf_pkg and csaf_top are compiled first
`timescale 1ns/1ps
module tb_top;
    import csaf_pkg::*;
    logic clk_in, rstn_in, wr, fix, cd1, cd2, to1, to2;
    logic [7:0] ptr, wd, rd, s1, s2;
    logic [11:0] cdat, p1, n1, p2, n2;
    logic [4:0] q1, q2;
    logic [3:0] st1, st2;
    logic h1, h2;
    logic [16:0] tc1, tc2;
    int error_cnt, checks;
    csaf_top i_csaf_top (.clk_in(clk_in), .rstn_in(rstn_in), .reg_wr_in(wr), .reg_ptr_in(ptr),
        .reg_wdata_in(wd), .reg_rdata_out(rd), .fixed_threshold_select_in(fix), .sens1_in(s1),
        .sens2_in(s2), .conv_done1_in(cd1), .conv_done2_in(cd2), .conv_data_in(cdat),
        .timeout1_in(to1), .timeout2_in(to2), .range_qpf1_out(q1), .range_qpf2_out(q2),
        .offset_dac_step1_out(st1), .offset_dac_step2_out(st2), .hyst_en1_out(h1),
        .hyst_en2_out(h2), .average_time_constant1_out(tc1), .average_time_constant2_out(tc2),
        .thr_pos1_out(p1), .thr_neg1_out(n1), .thr_pos2_out(p2), .thr_neg2_out(n2));
    csaf_host_model i_csaf_host_model (.clk_in(clk_in), .reg_wr_out(wr), .reg_ptr_out(ptr),
        .reg_wdata_out(wd));
    // clock
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // exact comparison
    task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // comparison within one count
    task automatic cmp_near(input logic [11:0] g, input int e);
        checks++;
        if ((^g === 1'bx) || (int'(g) > e + 1) || (int'(g) < e - 1))
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h near %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // preset values and an unmapped pointer
    task automatic t_reset;
        i_csaf_host_model.point(8'h0b);
        cmp_val(rd, 17'h0b);
        i_csaf_host_model.point(8'h0e);
        cmp_val(rd, 17'h0b);
        i_csaf_host_model.point(8'h0c);
        cmp_val(rd, 17'h00);
        cmp_val({q1, st1, h1, tc1}, {5'h08, 4'h4, 1'b1, 17'h01000});
        cmp_val({q2, st2, h2, tc2}, {5'h08, 4'h4, 1'b1, 17'h01000});
    endtask
    // every range code with settling boundaries, both channels
    task automatic t_range;
        logic [4:0] qt[4] = '{5'h08, 5'h02, 5'h04, 5'h10};
        logic [3:0] stt[4] = '{4'h4, 4'h1, 4'h2, 4'h8};
        logic [7:0] d;
        for (int r = 0; r < 4; r++)
        begin
            d = {r[1:0], 2'b00, 4'(r * 5)};
            i_csaf_host_model.wr(8'h0b, d | 8'h20);
            i_csaf_host_model.wr(8'h0e, d);
            cmp_val({q1, st1, tc1}, {qt[r], stt[r], 17'(1 << (r * 5 + 1))});
            cmp_val({q2, st2, tc2}, {qt[r], stt[r], 17'(1 << (r * 5 + 1))});
            i_csaf_host_model.point(8'h0b);
            cmp_val(rd, 17'(d));
        end
    endtask
    // hysteresis against mode and disable bit
    task automatic t_hyst;
        for (int m = 0; m < 4; m++)
        begin
            fix = m[1];
            i_csaf_host_model.wr(8'h0b, {3'h0, m[0], 4'h3});
            i_csaf_host_model.wr(8'h0e, {3'h0, m[0], 4'h3});
            cmp_val({h1, h2}, {2{~m[1] & ~m[0]}});
        end
        fix = 1'b0;
    endtask
    // one conversion on a channel, thresholds two cycles later
    task automatic conv(input int c, input logic [11:0] d, input logic t);
        cdat = d;
        {cd2, cd1} = (c == 1) ? 2'b10 : 2'b01;
        {to2, to1} = (c == 1) ? {t, 1'b0} : {1'b0, t};
        @(negedge clk_in);
        {cd2, cd1, to2, to1} = 4'h0;
        @(negedge clk_in);
        @(negedge clk_in);
    endtask
    // reload, saturation and exponential settling, settling field 3
    task automatic t_avg(input int c);
        real e;
        conv(c, 12'hff8, 1'b1);
        cmp_val(c ? {p2, n2} : {p1, n1}, {12'hfff, 12'hfe8});
        conv(c, 12'h005, 1'b1);
        cmp_val(c ? {p2, n2} : {p1, n1}, {12'h015, 12'h000});
        conv(c, 12'h000, 1'b1);
        e = 0.0;
        for (int n = 0; n < 6; n++)
        begin
            conv(c, 12'h800, 1'b0);
            e = e + (2048.0 - e) / 16.0;
            cmp_near(c ? p2 : p1, int'(e) + 16);
            cmp_near(c ? n2 : n1, int'(e) - 16);
        end
    endtask
    // watchdog
    initial
    begin
        #50000;
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        {rstn_in, fix, cd1, cd2, to1, to2} = 6'h00;
        s1 = 8'h10;
        s2 = 8'h10;
        cdat = 12'h000;
        error_cnt = 0;
        checks = 0;
        repeat (12) @(negedge clk_in);
        rstn_in = 1'b1;
        t_reset();
        t_range();
        t_hyst();
        t_avg(0);
        t_avg(1);
        print_verdict();
    end
endmodule // tb_top
